// ==== core/pbw_wait_gen.sv ====
// Wait-state generator between the CPU bus and the slow peripheral bus.
// Assumes one AHB-Lite master on the register port and a CPU that offers
// each access for one cycle and holds off the next until accDone.
// Behaviour
// - Accesses to listed slow registers raise a CPU wait for set clocks.
// - Clock conflicts make the CPU repeat the access; next instruction waits. Here no conflict is detected and no access is repeated.
// - Watchdog mode write waits 3 clocks; accumulator move takes 8.
// - Waitless writes take 5 clocks from accumulator, 7 with immediate.
// - UART receive status read waits 1 clock; read takes 6.
// - A/D mode, channel, power-fail writes and result reads wait variably.
// - A/D wait is two macro periods over CPU period plus one.
// - Fraction longer than CPU clock low width rounds the wait up.
// - Macro clock is fx/2 when speed bit 5 is 1, else fx/4.
// - A computed A/D wait of 1 yields no wait at all.
// - At fx 10 MHz waits are 9,5,3,2,0 and 5,3,2,0,0.
// - A result read with zero computed wait still waits one clock.
// - Stated waits hold with wait control 0; counts are CPU clocks.
//
// The address map and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "pbw_defs.svh"
module pbw_wait_gen
  import pbw_pkg::*;
#(
  parameter int FX_DIV = `PBW_FX_DIV,
  parameter int FX_PERIOD_NS = `PBW_FX_PERIOD_NS,
  parameter int CPUL_NS = `PBW_CPUL_NS
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire pbw_acc_t cpuAcc,
  output logic cpuWait,
  output logic accDone,
  output logic [4:0] execClocks
);
  logic rstMeta_r, rstSync_r, rstN;
  logic addrValid_r, addrValid_nxt, addrWrite_r, addrWrite_nxt;
  logic [7:0] addrOfs_r, addrOfs_nxt;
  logic [31:0] hrdata_r, hrdata_nxt, ctrl_r, ctrl_nxt;
  logic spdSel_r, spdSel_nxt;
  pbw_state_t state_r, state_nxt;
  logic [3:0] lastWait_r, lastWait_nxt, effWait, adcWait, cnt;
  logic [4:0] execClocks_r, execClocks_nxt, ratio, twoMacro, quot, rem;
  logic [4:0] adcRaw;
  logic [15:0] remNs;
  logic waitCtl, cpuTick, cntZero, cntLoad, start, roundUp;

  // Reset release through two flops; only the second is used.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end
  assign rstN = rstSync_r;

  // Address phase capture; reads are answered from a register next cycle.
  always_comb begin
    addrValid_nxt = addrValid_r;
    addrWrite_nxt = addrWrite_r;
    addrOfs_nxt = addrOfs_r;
    hrdata_nxt = hrdata_r;
    if (hready) begin
      addrValid_nxt = hsel && htrans[1];
      addrWrite_nxt = hwrite;
      addrOfs_nxt = haddr[7:0];
      hrdata_nxt = 32'h0000_0000;
      if (hsel && htrans[1] && !hwrite) begin
        if (haddr[7:0] == `PBW_CTRL_OFS) begin
          hrdata_nxt = ctrl_r;
        end else if (haddr[7:0] == `PBW_STAT_OFS) begin
          hrdata_nxt = {19'h0_0000, execClocks_r, 1'b0,
                        (state_r == PBW_STALL), spdSel_r, 1'b0, lastWait_r};
        end
      end
    end
  end

  // Bus slave registers.
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      addrValid_r <= 1'b0;
      addrWrite_r <= 1'b0;
      addrOfs_r <= 8'h00;
      hrdata_r <= 32'h0000_0000;
    end else begin
      addrValid_r <= addrValid_nxt;
      addrWrite_r <= addrWrite_nxt;
      addrOfs_r <= addrOfs_nxt;
      hrdata_r <= hrdata_nxt;
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  // Control register written in the data phase; A/D mode writes update
  // the speed select copy used for the macro clock.
  always_comb begin
    ctrl_nxt = ctrl_r;
    spdSel_nxt = spdSel_r;
    if (addrValid_r && addrWrite_r && addrOfs_r == `PBW_CTRL_OFS) begin
      ctrl_nxt = {26'h000_0000, hwdata[`PBW_CTRL_WCTL_BIT:0]};
    end
    if (start && cpuAcc.write && cpuAcc.regSel == PBW_ADC_MODE_REG) begin
      spdSel_nxt = cpuAcc.wdata[`PBW_SPEED_BIT];
    end
  end

  // Control registers.
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      ctrl_r <= `PBW_CTRL_RST;
      spdSel_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      spdSel_r <= spdSel_nxt;
    end
  end
  assign waitCtl = ctrl_r[`PBW_CTRL_WCTL_BIT];

  // CPU clock enable source.
  pbw_clk_div #(.FX_DIV(FX_DIV), .RW(5)) uDiv (
    .mclk(mclk),
    .rstN(rstN),
    .ratio(ratio),
    .cpuTick(cpuTick)
  );

  // A/D group wait from the macro and CPU clock periods, in fx periods.
  always_comb begin
    ratio = ctrl_r[`PBW_CTRL_RATIO_MSB:`PBW_CTRL_RATIO_LSB];
    if (ratio == 5'h00) begin
      ratio = 5'h01;
    end
    twoMacro = spdSel_r ? `PBW_TWO_MACRO_FAST : `PBW_TWO_MACRO_SLOW;
    quot = twoMacro / ratio;
    rem = twoMacro % ratio;
    remNs = 16'(rem) * 16'(FX_PERIOD_NS);
    roundUp = (quot != 5'h00) && (remNs > 16'(CPUL_NS));
    adcRaw = (quot == 5'h00) ? 5'h01 : quot + 5'h01 + 5'(roundUp);
    adcWait = (adcRaw == 5'h01) ? 4'h0 : adcRaw[3:0];
  end

  // Wait clocks for the access on offer, by register and direction.
  always_comb begin
    effWait = 4'h0;
    case (cpuAcc.regSel)
      PBW_WATCHDOG_MODE_REG: begin
        if (cpuAcc.write) begin
          effWait = `PBW_WDT_WAIT;
        end
      end
      PBW_UART_RX_STATUS_REG: begin
        if (!cpuAcc.write) begin
          effWait = `PBW_UART_WAIT;
        end
      end
      PBW_ADC_MODE_REG, PBW_ADC_CHANNEL_SELECT_REG,
      PBW_POWER_FAIL_COMPARE_MODE_REG, PBW_POWER_FAIL_THRESHOLD_REG: begin
        if (cpuAcc.write) begin
          effWait = adcWait;
        end
      end
      PBW_ADC_RESULT_REG: begin
        if (!cpuAcc.write) begin
          effWait = (adcWait == 4'h0) ? `PBW_RESULT_MIN : adcWait;
        end
      end
      default: begin
        effWait = 4'h0;
      end
    endcase
    effWait = effWait + 4'(waitCtl);
  end

  // Stall sequencer: an access that needs waits holds the CPU.
  assign start = (state_r == PBW_IDLE) && cpuAcc.valid;
  assign cntLoad = start && (effWait != 4'h0);
  always_comb begin
    state_nxt = state_r;
    lastWait_nxt = lastWait_r;
    execClocks_nxt = execClocks_r;
    accDone = 1'b0;
    case (state_r)
      PBW_IDLE: begin
        if (cpuAcc.valid) begin
          lastWait_nxt = effWait;
          execClocks_nxt = ((cpuAcc.write && cpuAcc.immediate) ?
            `PBW_BASE_IMM : `PBW_BASE_ACC) + 5'(effWait);
          if (effWait != 4'h0) begin
            state_nxt = PBW_STALL;
          end else begin
            accDone = 1'b1;
          end
        end
      end
      PBW_STALL: begin
        if (cntZero) begin
          state_nxt = PBW_IDLE;
          accDone = 1'b1;
        end
      end
      default: begin
        state_nxt = PBW_IDLE;
      end
    endcase
  end

  // Sequencer registers.
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      state_r <= PBW_IDLE;
      lastWait_r <= 4'h0;
      execClocks_r <= 5'h00;
    end else begin
      state_r <= state_nxt;
      lastWait_r <= lastWait_nxt;
      execClocks_r <= execClocks_nxt;
    end
  end

  // Wait clocks are counted on the CPU clock enable.
  pbw_wait_cnt #(.W(4)) uCnt (
    .mclk(mclk),
    .rstN(rstN),
    .load(cntLoad),
    .loadVal(effWait),
    .tick(cpuTick),
    .count(cnt),
    .zero(cntZero)
  );
  assign cpuWait = (state_r == PBW_STALL);
  assign execClocks = execClocks_r;

  // Checks on the wait figures and on the stall itself.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstN);

  sequence s_plain(pbw_reg_t r, logic w);
    start && !waitCtl && cpuAcc.regSel == r && cpuAcc.write == w;
  endsequence

  property p_wdt;
    s_plain(PBW_WATCHDOG_MODE_REG, 1'b1) ##0 !cpuAcc.immediate
      |=> cpuWait && lastWait_r == 4'h3 && execClocks_r == 5'h08;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog wait wrong");

  property p_uart;
    s_plain(PBW_UART_RX_STATUS_REG, 1'b0)
      |=> lastWait_r == 4'h1 && execClocks_r == 5'h06;
  endproperty
  a_uart: assert property (p_uart) else $error("uart wait wrong");

  property p_base;
    s_plain(PBW_OTHER_REG, 1'b1) ##0 cpuAcc.immediate
      |-> accDone ##1 !cpuWait && execClocks_r == 5'h07;
  endproperty
  a_base: assert property (p_base) else $error("plain write wrong");

  property p_table;
    s_plain(PBW_ADC_CHANNEL_SELECT_REG, 1'b1) ##0 ratio == 5'h01
      |=> lastWait_r == ($past(spdSel_r) ? 4'h5 : 4'h9);
  endproperty
  a_table: assert property (p_table) else $error("a/d wait wrong");

  property p_round;
    s_plain(PBW_ADC_MODE_REG, 1'b1) ##0 ratio == 5'h03 && !spdSel_r
      |=> lastWait_r == 4'h4;
  endproperty
  a_round: assert property (p_round) else $error("round up wrong");

  property p_nowait;
    s_plain(PBW_POWER_FAIL_THRESHOLD_REG, 1'b1) ##0 ratio == 5'h10
      |-> accDone ##1 !cpuWait && lastWait_r == 4'h0;
  endproperty
  a_nowait: assert property (p_nowait) else $error("wait of one");

  property p_result;
    s_plain(PBW_ADC_RESULT_REG, 1'b0) ##0 ratio == 5'h10
      |=> cpuWait && lastWait_r == 4'h1 && execClocks_r == 5'h06;
  endproperty
  a_result: assert property (p_result) else $error("result wait");

  property p_hold;
    cpuWait && !cntZero |=> cpuWait;
  endproperty
  a_hold: assert property (p_hold) else $error("stall dropped");

  property p_speed;
    start && cpuAcc.write && cpuAcc.regSel == PBW_ADC_MODE_REG
      |=> spdSel_r == $past(cpuAcc.wdata[5]);
  endproperty
  a_speed: assert property (p_speed) else $error("speed bit");

  property p_wctl;
    start && waitCtl && cpuAcc.regSel == PBW_OTHER_REG
      |=> cpuWait && lastWait_r == 4'h1;
  endproperty
  a_wctl: assert property (p_wctl) else $error("wait control");
endmodule

// ==== core/pbw_defs.svh ====
// Constants of the peripheral bus wait generator: offsets, fields, timing.
// Assumes inclusion by bare name from the generator, divider and bench files.
`ifndef PBW_DEFS_SVH
`define PBW_DEFS_SVH
// Register byte offsets, decoded on the low address byte.
`define PBW_CTRL_OFS 8'h00
`define PBW_STAT_OFS 8'h04
// Control fields: CPU clock ratio to fx and the wait control bit.
`define PBW_CTRL_RATIO_LSB 0
`define PBW_CTRL_RATIO_MSB 4
`define PBW_CTRL_WCTL_BIT 5
`define PBW_CTRL_RST 32'h0000_0001
// Conversion speed select position inside an A/D mode write.
`define PBW_SPEED_BIT 5
// Timing: clock rates as times, and the derived fx divider.
`define PBW_MCLK_PERIOD_NS 10
`define PBW_FX_PERIOD_NS 100
`define PBW_FX_DIV (`PBW_FX_PERIOD_NS / `PBW_MCLK_PERIOD_NS)
`define PBW_CPUL_NS 50
// Fixed waits and baseline instruction lengths in CPU clocks.
`define PBW_WDT_WAIT 4'h3
`define PBW_UART_WAIT 4'h1
`define PBW_RESULT_MIN 4'h1
`define PBW_BASE_ACC 5'h05
`define PBW_BASE_IMM 5'h07
// Twice the A/D macro clock period in fx periods, per speed select.
`define PBW_TWO_MACRO_FAST 5'h04
`define PBW_TWO_MACRO_SLOW 5'h08
`endif

// ==== core/pbw_pkg.sv ====
// Types shared by the wait generator files.
// Assumes nothing beyond a SystemVerilog compiler.
package pbw_pkg;
  // Peripheral register that a CPU access addresses.
  typedef enum logic [2:0] {
    PBW_OTHER_REG = 3'h0,
    PBW_WATCHDOG_MODE_REG = 3'h1,
    PBW_UART_RX_STATUS_REG = 3'h2,
    PBW_ADC_MODE_REG = 3'h3,
    PBW_ADC_CHANNEL_SELECT_REG = 3'h4,
    PBW_POWER_FAIL_COMPARE_MODE_REG = 3'h5,
    PBW_POWER_FAIL_THRESHOLD_REG = 3'h6,
    PBW_ADC_RESULT_REG = 3'h7
  } pbw_reg_t;
  // One CPU peripheral access, presented for one cycle.
  typedef struct packed {
    logic valid;
    logic write;
    logic immediate;
    pbw_reg_t regSel;
    logic [7:0] wdata;
  } pbw_acc_t;
  // Stall sequencer states.
  typedef enum logic [1:0] {
    PBW_IDLE = 2'b01,
    PBW_STALL = 2'b10
  } pbw_state_t;
endpackage

// ==== core/pbw_clk_div.sv ====
// CPU clock enable: mclk divided to fx, then by the CPU clock ratio.
// Assumes an asynchronous active-low reset already released cleanly.
`timescale 1ns/100ps
`include "pbw_defs.svh"
module pbw_clk_div #(
  parameter int FX_DIV = `PBW_FX_DIV,
  parameter int RW = 5
) (
  input wire logic mclk,
  input wire logic rstN,
  input wire logic [RW-1:0] ratio,
  output logic cpuTick
);
  logic [7:0] fxCnt_r, fxCnt_nxt;
  logic [RW-1:0] cpuCnt_r, cpuCnt_nxt;
  logic fxTick;

  // The fx enable fires once every FX_DIV mclk cycles.
  assign fxTick = (fxCnt_r == 8'(FX_DIV - 1));
  // The CPU enable fires on every ratio-th fx enable; ratio 0 acts as 1.
  always_comb begin
    fxCnt_nxt = fxTick ? 8'h00 : fxCnt_r + 8'h01;
    cpuCnt_nxt = cpuCnt_r;
    cpuTick = 1'b0;
    if (fxTick) begin
      if (cpuCnt_r + RW'(1) >= ratio) begin
        cpuCnt_nxt = '0;
        cpuTick = 1'b1;
      end else begin
        cpuCnt_nxt = cpuCnt_r + RW'(1);
      end
    end
  end

  // Counter registers.
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      fxCnt_r <= 8'h00;
      cpuCnt_r <= '0;
    end else begin
      fxCnt_r <= fxCnt_nxt;
      cpuCnt_r <= cpuCnt_nxt;
    end
  end
endmodule

// ==== core/pbw_wait_cnt.sv ====
// Down-counter of CPU wait clocks, loaded at the start of a stall.
// Assumes tick is a one-cycle enable at the CPU clock rate.
`timescale 1ns/100ps
module pbw_wait_cnt #(
  parameter int W = 4
) (
  input wire logic mclk,
  input wire logic rstN,
  input wire logic load,
  input wire logic [W-1:0] loadVal,
  input wire logic tick,
  output logic [W-1:0] count,
  output logic zero
);
  logic [W-1:0] cnt_r, cnt_nxt;

  // Load wins over a decrement; the count stops at zero.
  always_comb begin
    cnt_nxt = cnt_r;
    if (load) begin
      cnt_nxt = loadVal;
    end else if (tick && cnt_r != '0) begin
      cnt_nxt = cnt_r - W'(1);
    end
  end

  // Count register.
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign count = cnt_r;
  assign zero = (cnt_r == '0);
endmodule

// ==== verification/pbw_cpu_model.sv ====
// CPU core model that offers peripheral accesses to the wait generator.
// Assumes the generator's clock and its access-finished pulse.
`timescale 1ns/100ps
module pbw_cpu_model
  import pbw_pkg::*;
(
  input wire logic mclk,
  input wire logic accDone,
  input wire logic cpuWait,
  output pbw_acc_t cpuAcc
);
  // The access bus starts released.
  initial cpuAcc = '0;

  // Offers one access and holds off the next until it finishes.
  // A poke re-offers a watchdog write during the stall, which is ignored.
  // A released bus shows inverted fields so stale values never pass.
  // The count s gives the waited cycles in which the stall was seen high.
  task automatic run(input pbw_acc_t a, input logic poke, output int n,
      output int s);
    pbw_acc_t pk;
    pk = a;
    pk.regSel = PBW_WATCHDOG_MODE_REG;
    pk.write = 1'h1;
    n = 0;
    s = 0;
    @(posedge mclk);
    cpuAcc <= a;
    @(negedge mclk);
    while (accDone !== 1'h1 && n < 4000) begin
      @(posedge mclk);
      cpuAcc <= poke ? pk : a ^ 14'h3FFF;
      n++;
      @(negedge mclk);
      if (cpuWait === 1'h1) s++;
    end
    @(posedge mclk);
    cpuAcc <= a ^ 14'h3FFF;
  endtask
endmodule

// ==== verification/testbench.sv ====
// Self-checking bench for the peripheral bus wait generator.
// Assumes the design files and the CPU model are compiled before it.
`timescale 1ns/100ps
`include "pbw_defs.svh"
module testbench
  import pbw_pkg::*;
;
  logic mclk, rst_n, hsel, hwrite, hreadyOut, hresp, cpuWait, accDone;
  logic [31:0] haddr, hwdata, hrdata, rd, seed;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [4:0] execClocks;
  logic spd;
  pbw_acc_t cpuAcc, acc;
  int miscompares, checked, ratio, wc;
  int tbl[2][5] = '{'{9, 5, 3, 2, 0}, '{5, 3, 2, 0, 0}};

  pbw_wait_gen u_pbw_wait_gen (
    .mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyOut), .hreadyout(hreadyOut), .hrdata(hrdata),
    .hresp(hresp), .cpuAcc(cpuAcc), .cpuWait(cpuWait),
    .accDone(accDone), .execClocks(execClocks)
  );

  pbw_cpu_model u_pbw_cpu_model (
    .mclk(mclk), .accDone(accDone), .cpuWait(cpuWait), .cpuAcc(cpuAcc)
  );

  // Free-running 100 MHz clock.
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end

  // Cuts a hang short well beyond the cycle count of a full run.
  initial begin
    repeat (90000) @(posedge mclk);
    miscompares++;
    give_verdict();
  end

  // Counts a comparison and reports a mismatch at once.
  task automatic check(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Xorshift step for repeatable random stimulus.
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Expected CPU wait clocks of one access at a ratio and speed select.
  // Twice the macro period is 4 fx periods when fast and 8 when slow.
  function automatic int exp_wait(pbw_acc_t a, int r, logic f);
    int m, q;
    m = f ? 4 : 8;
    q = m / r;
    if (q >= 1 && (m % r) * `PBW_FX_PERIOD_NS > `PBW_CPUL_NS) q++;
    q = (q == 0) ? 0 : q + 1;
    case (a.regSel)
      PBW_OTHER_REG: return 0;
      PBW_WATCHDOG_MODE_REG: return a.write ? 3 : 0;
      PBW_UART_RX_STATUS_REG: return a.write ? 0 : 1;
      PBW_ADC_RESULT_REG: return a.write ? 0 : (q == 0 ? 1 : q);
      default: return a.write ? q : 0;
    endcase
  endfunction

  // One single AHB-Lite word transfer; read data is taken at the end.
  task automatic ahb(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r);
    @(posedge mclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge mclk);
    while (hreadyOut !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk);
    while (hreadyOut !== 1'h1);
    r = hrdata;
    hsel <= 1'h0;
  endtask

  // Runs one access and checks stall length, clocks and status word.
  task automatic access(input pbw_acc_t a, input logic poke);
    int n, s, w, e, p;
    w = exp_wait(a, ratio, spd) + wc;
    e = (a.write && a.immediate ? 7 : 5) + w;
    p = `PBW_FX_DIV * ratio;
    u_pbw_cpu_model.run(a, poke, n, s);
    check("stall", w == 0 ? n == 0 : n > (w - 1) * p && n <= w * p + 1,
      1);
    check("cpuWait", s, n);
    @(negedge mclk);
    check("cpuWaitOff", cpuWait, 0);
    check("execClocks", execClocks, e);
    if (a.write && a.regSel == PBW_ADC_MODE_REG) spd = a.wdata[5];
    ahb(1'h0, `PBW_STAT_OFS, 32'h0, rd);
    check("status", rd, {19'h0, e[4:0], 2'h0, spd, 1'h0, w[3:0]});
  endtask

  // Reset, register map, wait table walk, sweep, then random accesses.
  initial begin
    rst_n = 1'h0;
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    miscompares = 0;
    checked = 0;
    ratio = 1;
    spd = 1'h0;
    wc = 0;
    seed = 32'h0072;
    repeat (8) @(posedge mclk);
    rst_n <= 1'h1;
    repeat (5) @(posedge mclk);
    check("hresp", hresp, 0);
    check("hreadyout", hreadyOut, 1);
    ahb(1'h0, `PBW_CTRL_OFS, 32'h0, rd);
    check("ctrlReset", rd, `PBW_CTRL_RST);
    ahb(1'h1, `PBW_STAT_OFS, 32'hFFFF, rd);
    ahb(1'h1, 8'h08, 32'h5A, rd);
    ahb(1'h0, `PBW_STAT_OFS, 32'h0, rd);
    check("statReadOnly", rd, 0);
    ahb(1'h0, 8'h08, 32'h0, rd);
    check("unmapped", rd, 0);
    for (int f = 0; f < 2; f++) begin
      acc = '{1'h1, 1'h1, 1'h0, PBW_ADC_MODE_REG, 8'(f << 5)};
      access(acc, 1'h0);
      for (int k = 0; k < 5; k++) begin
        ratio = 1 << k;
        ahb(1'h1, `PBW_CTRL_OFS, 32'(ratio), rd);
        acc = '{1'h1, 1'h1, 1'h0, k == 4 ? PBW_POWER_FAIL_THRESHOLD_REG :
          PBW_ADC_CHANNEL_SELECT_REG, 8'h0};
        access(acc, 1'h1);
        check("adcWrite", execClocks, 5 + tbl[f][k]);
        acc = '{1'h1, 1'h0, 1'h0, PBW_ADC_RESULT_REG, 8'h0};
        access(acc, 1'h0);
        check("adcRead", execClocks,
          5 + (tbl[f][k] == 0 ? 1 : tbl[f][k]));
      end
    end
    // Wait control set adds one wait clock to every access at ratio 3.
    ratio = 3;
    wc = 1;
    ahb(1'h1, `PBW_CTRL_OFS, 32'h23, rd);
    ahb(1'h0, `PBW_CTRL_OFS, 32'h0, rd);
    check("ctrl", rd, 32'h23);
    for (int r = 0; r < 8; r++) begin
      acc = '{1'h1, r[0], 1'h0, pbw_reg_t'(r[2:0]), 8'h0};
      access(acc, 1'h0);
    end
    wc = 0;
    ahb(1'h1, `PBW_CTRL_OFS, 32'h3, rd);
    for (int r = 0; r < 16; r++) begin
      acc = '{1'h1, r[3], r[3], pbw_reg_t'(r[2:0]), 8'h0};
      access(acc, r[0]);
    end
    for (int i = 0; i < 40; i++) begin
      seed = xs(seed);
      if (seed[7:5] == 3'h0) begin
        ratio = 1 + seed[12:8] % 31;
        ahb(1'h1, `PBW_CTRL_OFS, 32'(ratio), rd);
      end
      acc = '{1'h1, seed[3], seed[3] & seed[4], pbw_reg_t'(seed[2:0]),
        seed[20:13]};
      access(acc, seed[21]);
    end
    give_verdict();
  end
endmodule
